// ---- zmpri_params.svh ----
// constants for the zone merge controller register bank
// assumes includers use the macro names only
`ifndef ZMPRI_PARAMS_SVH
`define ZMPRI_PARAMS_SVH
// module register addresses
`define ZMPRI_CLR_FAULT 16'h0016
`define ZMPRI_SENSOR_IN 16'h0023
`define ZMPRI_LSPEED 16'h0028
`define ZMPRI_AUX_OUT 16'h003f
`define ZMPRI_RSPEED 16'h0040
`define ZMPRI_MSTAT1 16'h0058
`define ZMPRI_MSTAT2 16'h0059
`define ZMPRI_UP_CTRL 16'h0068
`define ZMPRI_UP_REL 16'h0069
`define ZMPRI_UP_ARR 16'h006a
`define ZMPRI_UP_DEP 16'h006b
`define ZMPRI_UP_JAMCLR 16'h006d
`define ZMPRI_UP_STAT 16'h0074
`define ZMPRI_INDUCT 16'h0086
`define ZMPRI_DN_CTRL 16'h00b8
`define ZMPRI_DN_REL 16'h00b9
`define ZMPRI_DN_ARR 16'h00ba
`define ZMPRI_DN_DEP 16'h00bb
`define ZMPRI_DN_JAMCLR 16'h00bd
`define ZMPRI_DN_STAT 16'h00c4
`define ZMPRI_DISCH 16'h00e8
`define ZMPRI_UP_DIR 16'h016d
`define ZMPRI_DN_DIR 16'h0177
`define ZMPRI_ADDR_NONE 16'hffff
// assembly layout
`define ZMPRI_IN_WORDS 5'h0c
`define ZMPRI_OUT_WORDS 5'h0f
`define ZMPRI_IN_BASE 16'h0b54
`define ZMPRI_OUT_BASE 16'h0bb8
// control bit positions
`define ZMPRI_BIT_ACCUM 0
`define ZMPRI_BIT_HOLD_UP 8
`define ZMPRI_BIT_WAKE 12
// zone status codes, discharge full value, induct wake value
`define ZMPRI_ST_CLEAR 8'h01
`define ZMPRI_ST_BUSY 8'h02
`define ZMPRI_ST_ARR_RUN 8'h04
`define ZMPRI_ST_ARR_STOP 8'h05
`define ZMPRI_DISCH_FULL 16'h0005
`define ZMPRI_INDUCT_WAKE 16'h0004
// reset and timing
`define ZMPRI_REG_RST 16'h0000
`define ZMPRI_SYNC_W 5
`define ZMPRI_CLK_MHZ 100
`define ZMPRI_JAM_TIME_MS 5000
`define ZMPRI_JAM_CYCLES (`ZMPRI_JAM_TIME_MS * 1000 * `ZMPRI_CLK_MHZ)
`endif

// ---- zmpri_pkg.sv ----
// types of the zone merge controller register bank
// assumes nothing outside
package zmpri_pkg;
  typedef logic [15:0] zmpri_word_t;
  typedef logic [7:0] zmpri_byte_t;
  typedef logic [4:0] zmpri_bidx_t;
endpackage : zmpri_pkg

// ---- zmpri_top.sv ----
// zone merge controller: register bank, cyclic assemblies, two-zone accumulation logic
// assumes one 100 MHz clock, sensor and neighbour pins asynchronous to it
`timescale 1ns/1ps
`include "zmpri_params.svh"

module zmpri_top #(
  parameter int unsigned JAM_CYCLES = `ZMPRI_JAM_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input zmpri_pkg::zmpri_word_t reg_wdata,
  output zmpri_pkg::zmpri_word_t reg_rdata,
  input zmpri_pkg::zmpri_bidx_t asm_in_idx,
  output zmpri_pkg::zmpri_byte_t asm_in_data,
  input zmpri_pkg::zmpri_bidx_t asm_out_idx,
  input wire logic asm_out_wr,
  input zmpri_pkg::zmpri_byte_t asm_out_data,
  input wire logic [3:0] sensor_pins,
  input wire logic upstream_feed_pin,
  input zmpri_pkg::zmpri_word_t module_status2_in,
  output logic [1:0] roller_motor_run,
  output logic upstream_neighbour_hold,
  output logic downstream_release,
  output zmpri_pkg::zmpri_word_t left_speed,
  output zmpri_pkg::zmpri_word_t right_speed,
  output zmpri_pkg::zmpri_word_t aux_out,
  output zmpri_pkg::zmpri_word_t clear_fault,
  output zmpri_pkg::zmpri_word_t up_dir_mode,
  output zmpri_pkg::zmpri_word_t dn_dir_mode
);
  import zmpri_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, change taken when stages two and three agree
  logic [`ZMPRI_SYNC_W-1:0] filt;
  for (genvar i = 0; i < `ZMPRI_SYNC_W; i++) begin : g_sync
    logic s1_q, s2_q, s3_q, f_q, f_d;
    always_comb begin
      f_d = (s2_q == s3_q) ? s3_q : f_q;
    end
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
        f_q <= 1'b0;
      end else begin
        s1_q <= (i < 4) ? sensor_pins[i % 4] : upstream_feed_pin;
        s2_q <= s1_q;
        s3_q <= s2_q;
        f_q <= f_d;
      end
    end
    assign filt[i] = f_q;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // assembly word maps
  function automatic zmpri_word_t in_map(input logic [3:0] w);
    case (w)
      4'h0: in_map = `ZMPRI_UP_STAT;
      4'h1: in_map = `ZMPRI_DN_STAT;
      4'h2: in_map = `ZMPRI_UP_ARR;
      4'h3: in_map = `ZMPRI_UP_DEP;
      4'h4: in_map = `ZMPRI_DN_ARR;
      4'h5: in_map = `ZMPRI_DN_DEP;
      4'h6: in_map = `ZMPRI_MSTAT1;
      4'h7: in_map = `ZMPRI_MSTAT2;
      4'h8: in_map = `ZMPRI_UP_REL;
      4'h9: in_map = `ZMPRI_DN_REL;
      4'ha: in_map = `ZMPRI_SENSOR_IN;
      default: in_map = `ZMPRI_ADDR_NONE;
    endcase
  endfunction : in_map

  function automatic zmpri_word_t out_map(input logic [3:0] w);
    case (w)
      4'h0: out_map = `ZMPRI_UP_CTRL;
      4'h1: out_map = `ZMPRI_DN_CTRL;
      4'h2: out_map = `ZMPRI_LSPEED;
      4'h3: out_map = `ZMPRI_RSPEED;
      4'h4: out_map = `ZMPRI_UP_REL;
      4'h5: out_map = `ZMPRI_DN_REL;
      4'h6: out_map = `ZMPRI_INDUCT;
      4'h7: out_map = `ZMPRI_DISCH;
      4'h8: out_map = `ZMPRI_CLR_FAULT;
      4'h9: out_map = `ZMPRI_AUX_OUT;
      4'hb: out_map = `ZMPRI_UP_JAMCLR;
      4'hc: out_map = `ZMPRI_DN_JAMCLR;
      4'hd: out_map = `ZMPRI_UP_DIR;
      4'he: out_map = `ZMPRI_DN_DIR;
      default: out_map = `ZMPRI_ADDR_NONE;
    endcase
  endfunction : out_map

  ////////////////////////////////////////////////////////////////////////////////
  // write path: register port wins over an assembly word commit
  zmpri_byte_t hi_q, hi_d;
  logic wr_en;
  zmpri_word_t wr_addr, wr_data;
  always_comb begin
    hi_d = hi_q;
    wr_en = 1'b0;
    wr_addr = `ZMPRI_ADDR_NONE;
    wr_data = `ZMPRI_REG_RST;
    if (asm_out_wr && asm_out_idx < (`ZMPRI_OUT_WORDS * 5'h02)) begin
      if (!asm_out_idx[0]) begin
        hi_d = asm_out_data;
      end else begin
        wr_en = 1'b1;
        wr_addr = out_map(asm_out_idx[4:1]);
        wr_data = {hi_q, asm_out_data};
      end
    end
    if (reg_wr) begin
      wr_en = 1'b1;
      wr_addr = reg_addr;
      wr_data = reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // stored control registers
  zmpri_word_t ctrl_q [2], ctrl_d [2];
  zmpri_word_t jclr_q [2], jclr_d [2];
  zmpri_word_t lsp_q, lsp_d, rsp_q, rsp_d, aux_q, aux_d, cf_q, cf_d;
  zmpri_word_t ind_q, ind_d, dis_q, dis_d, dir_q [2], dir_d [2];
  logic [1:0] wr_ctrl, wr_rel, wr_jam;
  always_comb begin
    ctrl_d = ctrl_q;
    jclr_d = jclr_q;
    dir_d = dir_q;
    lsp_d = lsp_q;
    rsp_d = rsp_q;
    aux_d = aux_q;
    cf_d = cf_q;
    ind_d = ind_q;
    dis_d = dis_q;
    wr_ctrl = 2'b00;
    wr_rel = 2'b00;
    wr_jam = 2'b00;
    if (wr_en) begin
      case (wr_addr)
        `ZMPRI_UP_CTRL: begin
          ctrl_d[0] = wr_data;
          wr_ctrl[0] = 1'b1;
        end
        `ZMPRI_DN_CTRL: begin
          ctrl_d[1] = wr_data;
          wr_ctrl[1] = 1'b1;
        end
        `ZMPRI_UP_REL: wr_rel[0] = 1'b1;
        `ZMPRI_DN_REL: wr_rel[1] = 1'b1;
        `ZMPRI_UP_JAMCLR: begin
          jclr_d[0] = wr_data;
          wr_jam[0] = 1'b1;
        end
        `ZMPRI_DN_JAMCLR: begin
          jclr_d[1] = wr_data;
          wr_jam[1] = 1'b1;
        end
        `ZMPRI_LSPEED: lsp_d = wr_data;
        `ZMPRI_RSPEED: rsp_d = wr_data;
        `ZMPRI_AUX_OUT: aux_d = wr_data;
        `ZMPRI_CLR_FAULT: cf_d = wr_data;
        `ZMPRI_INDUCT: ind_d = wr_data;
        `ZMPRI_DISCH: dis_d = wr_data;
        `ZMPRI_UP_DIR: dir_d[0] = wr_data;
        `ZMPRI_DN_DIR: dir_d[1] = wr_data;
        default: wr_ctrl = 2'b00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hi_q <= 8'h00;
      ctrl_q <= '{`ZMPRI_REG_RST, `ZMPRI_REG_RST};
      jclr_q <= '{`ZMPRI_REG_RST, `ZMPRI_REG_RST};
      dir_q <= '{`ZMPRI_REG_RST, `ZMPRI_REG_RST};
      lsp_q <= `ZMPRI_REG_RST;
      rsp_q <= `ZMPRI_REG_RST;
      aux_q <= `ZMPRI_REG_RST;
      cf_q <= `ZMPRI_REG_RST;
      ind_q <= `ZMPRI_REG_RST;
      dis_q <= `ZMPRI_REG_RST;
    end else begin
      hi_q <= hi_d;
      ctrl_q <= ctrl_d;
      jclr_q <= jclr_d;
      dir_q <= dir_d;
      lsp_q <= lsp_d;
      rsp_q <= rsp_d;
      aux_q <= aux_d;
      cf_q <= cf_d;
      ind_q <= ind_d;
      dis_q <= dis_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // zone motion: index 0 upstream zone, 1 downstream zone
  logic [1:0] occ, hold, go, run, jam, relreq, accnext;
  zmpri_word_t arr [2], dep [2], relcnt [2];
  logic feed_up;
  assign occ = filt[1:0];
  always_comb begin
    hold[0] = ctrl_q[0][`ZMPRI_BIT_ACCUM] | accnext[0] | ctrl_q[1][`ZMPRI_BIT_HOLD_UP];
    hold[1] = ctrl_q[1][`ZMPRI_BIT_ACCUM] | accnext[1];
    go = ~hold | relreq;
    feed_up = ctrl_q[0][`ZMPRI_BIT_WAKE] | (ind_q == `ZMPRI_INDUCT_WAKE) | filt[4];
    // upstream zone passes into an empty downstream zone
    run[0] = ~jam[0] & ((occ[0] & go[0] & ~occ[1]) | (~occ[0] & feed_up));
    // a full and stopped discharge keeps the load in place
    run[1] = ~jam[1] & ((occ[1] & go[1] & (dis_q != `ZMPRI_DISCH_FULL))
             | (~occ[1] & occ[0] & go[0]));
  end

  for (genvar z = 0; z < 2; z++) begin : g_zone
    logic prev_q, jam_q, jam_d, req_q, req_d, acc_q, acc_d, arrive, depart;
    zmpri_word_t arr_q, arr_d, dep_q, dep_d, rc_q, rc_d;
    logic [31:0] jc_q, jc_d;
    always_comb begin
      arrive = occ[z] & ~prev_q;
      depart = ~occ[z] & prev_q;
      arr_d = arrive ? arr_q + 16'h0001 : arr_q;
      dep_d = depart ? dep_q + 16'h0001 : dep_q;
      rc_d = (depart & req_q) ? rc_q + 16'h0001 : rc_q;
      req_d = wr_rel[z] ? 1'b1 : (depart ? 1'b0 : req_q);
      acc_d = (depart & req_q) ? 1'b1 : (wr_ctrl[z] ? 1'b0 : acc_q);
      jc_d = (run[z] & occ[z]) ? jc_q + 32'h0000_0001 : 32'h0000_0000;
      jam_d = (jc_q == JAM_CYCLES - 1) ? 1'b1 : (wr_jam[z] ? 1'b0 : jam_q);
    end
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        prev_q <= 1'b0;
        arr_q <= `ZMPRI_REG_RST;
        dep_q <= `ZMPRI_REG_RST;
        rc_q <= `ZMPRI_REG_RST;
        req_q <= 1'b0;
        acc_q <= 1'b0;
        jc_q <= 32'h0000_0000;
        jam_q <= 1'b0;
      end else begin
        prev_q <= occ[z];
        arr_q <= arr_d;
        dep_q <= dep_d;
        rc_q <= rc_d;
        req_q <= req_d;
        acc_q <= acc_d;
        jc_q <= jc_d;
        jam_q <= jam_d;
      end
    end
    assign arr[z] = arr_q;
    assign dep[z] = dep_q;
    assign relcnt[z] = rc_q;
    assign jam[z] = jam_q;
    assign relreq[z] = req_q;
    assign accnext[z] = acc_q;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // zone status and read mux
  function automatic zmpri_word_t zstat(input logic o, input logic r);
    zstat = {8'h00, o ? (r ? `ZMPRI_ST_ARR_RUN : `ZMPRI_ST_ARR_STOP)
                      : (r ? `ZMPRI_ST_BUSY : `ZMPRI_ST_CLEAR)};
  endfunction : zstat

  function automatic zmpri_word_t rd_val(input zmpri_word_t a);
    case (a)
      `ZMPRI_UP_STAT: rd_val = zstat(occ[0], run[0]);
      `ZMPRI_DN_STAT: rd_val = zstat(occ[1], run[1]);
      `ZMPRI_UP_ARR: rd_val = arr[0];
      `ZMPRI_UP_DEP: rd_val = dep[0];
      `ZMPRI_DN_ARR: rd_val = arr[1];
      `ZMPRI_DN_DEP: rd_val = dep[1];
      `ZMPRI_MSTAT1: rd_val = {14'h0000, jam};
      `ZMPRI_MSTAT2: rd_val = module_status2_in;
      `ZMPRI_UP_REL: rd_val = relcnt[0];
      `ZMPRI_DN_REL: rd_val = relcnt[1];
      `ZMPRI_SENSOR_IN: rd_val = {12'h000, filt[3:0]};
      `ZMPRI_UP_CTRL: rd_val = ctrl_q[0];
      `ZMPRI_DN_CTRL: rd_val = ctrl_q[1];
      `ZMPRI_LSPEED: rd_val = lsp_q;
      `ZMPRI_RSPEED: rd_val = rsp_q;
      `ZMPRI_INDUCT: rd_val = ind_q;
      `ZMPRI_DISCH: rd_val = dis_q;
      `ZMPRI_CLR_FAULT: rd_val = cf_q;
      `ZMPRI_AUX_OUT: rd_val = aux_q;
      `ZMPRI_UP_JAMCLR: rd_val = jclr_q[0];
      `ZMPRI_DN_JAMCLR: rd_val = jclr_q[1];
      `ZMPRI_UP_DIR: rd_val = dir_q[0];
      `ZMPRI_DN_DIR: rd_val = dir_q[1];
      default: rd_val = `ZMPRI_REG_RST;
    endcase
  endfunction : rd_val

  ////////////////////////////////////////////////////////////////////////////////
  // registered outputs
  zmpri_word_t rdata_q, rdata_d, in_word;
  zmpri_byte_t ib_q, ib_d;
  logic [1:0] run_q;
  logic hold_q, rel_q;
  always_comb begin
    rdata_d = reg_rd ? rd_val(reg_addr) : rdata_q;
    in_word = (asm_in_idx < (`ZMPRI_IN_WORDS * 5'h02)) ? rd_val(in_map(asm_in_idx[4:1]))
              : `ZMPRI_REG_RST;
    ib_d = asm_in_idx[0] ? in_word[7:0] : in_word[15:8];
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= `ZMPRI_REG_RST;
      ib_q <= 8'h00;
      run_q <= 2'b00;
      hold_q <= 1'b0;
      rel_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      ib_q <= ib_d;
      run_q <= run;
      hold_q <= ctrl_q[0][`ZMPRI_BIT_HOLD_UP];
      rel_q <= run[1] & occ[1];
    end
  end

  assign reg_rdata = rdata_q;
  assign asm_in_data = ib_q;
  assign roller_motor_run = run_q;
  assign upstream_neighbour_hold = hold_q;
  assign downstream_release = rel_q;
  assign left_speed = lsp_q;
  assign right_speed = rsp_q;
  assign aux_out = aux_q;
  assign clear_fault = cf_q;
  assign up_dir_mode = dir_q[0];
  assign dn_dir_mode = dir_q[1];
endmodule : zmpri_top

// ---- zmpri_top_monitor.sv ----
// checker for the zone merge register bank ports
// assumes a bind onto zmpri_top, one clock domain
`timescale 1ns/1ps
module zmpri_monitor #(
  parameter int unsigned JAM_CYCLES = 20
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input zmpri_pkg::zmpri_word_t reg_wdata,
  input zmpri_pkg::zmpri_word_t reg_rdata,
  input zmpri_pkg::zmpri_bidx_t asm_in_idx,
  input zmpri_pkg::zmpri_byte_t asm_in_data,
  input zmpri_pkg::zmpri_bidx_t asm_out_idx,
  input wire logic asm_out_wr,
  input zmpri_pkg::zmpri_byte_t asm_out_data,
  input wire logic [3:0] sensor_pins,
  input wire logic [1:0] roller_motor_run,
  input wire logic upstream_neighbour_hold,
  input wire logic downstream_release
);
  import zmpri_pkg::*;
  zmpri_word_t ctl_q, ctl_d, dis_q, dis_d;
  zmpri_byte_t hi_q, hi_d;
  logic [31:0] run_q, run_d;
  ////////////////////////////////////////////////////////////////
  // shadow of upstream control, discharge status, run time
  always_comb begin
    ctl_d = ctl_q;
    dis_d = dis_q;
    hi_d = (asm_out_wr && !asm_out_idx[0] && asm_out_idx < 5'd30) ? asm_out_data : hi_q;
    run_d = (roller_motor_run[0] && sensor_pins[0]) ? run_q + 32'h1 : 32'h0;
    if (reg_wr && reg_addr == 16'h0068)
      ctl_d = reg_wdata;
    else if (!reg_wr && asm_out_wr && asm_out_idx == 5'h01)
      ctl_d = {hi_q, asm_out_data};
    if (reg_wr && reg_addr == 16'h00e8)
      dis_d = reg_wdata;
    else if (!reg_wr && asm_out_wr && asm_out_idx == 5'h0f)
      dis_d = {hi_q, asm_out_data};
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_q <= 16'h0000;
      dis_q <= 16'h0000;
      hi_q <= 8'h00;
      run_q <= 32'h0;
    end else begin
      ctl_q <= ctl_d;
      dis_q <= dis_d;
      hi_q <= hi_d;
      run_q <= run_d;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_hold_set;
    $rose(ctl_q[8]);
  endsequence
  sequence s_stat_rd;
    reg_rd && reg_addr == 16'h0074;
  endsequence
  hold_set_a: assert property (s_hold_set |=> upstream_neighbour_hold)
    else $error("neighbour hold missing after bit 8 set");
  hold_clr_a: assert property ($fell(ctl_q[8]) |=> !upstream_neighbour_hold)
    else $error("neighbour hold stuck after bit 8 cleared");
  wake_run_a: assert property ((ctl_q[12] && !sensor_pins[0])[*6] |-> roller_motor_run[0])
    else $error("upstream motor idle while woken");
  jam_stop_a: assert property (run_q < JAM_CYCLES + 8)
    else $error("occupied motor ran past jam time");
  disch_hold_a: assert property ((dis_q == 16'h0005)[*4] |-> !downstream_release)
    else $error("downstream release while discharge full");
  rsv_in_a: assert property (asm_in_idx >= 5'd22 |=> asm_in_data == 8'h00)
    else $error("reserved input byte not zero");
  stat_code_a: assert property (s_stat_rd |=> reg_rdata[15:8] == 8'h00 &&
    reg_rdata[7:0] inside {8'h01, 8'h02, 8'h04, 8'h05})
    else $error("illegal upstream status code");
  unmapped_a: assert property (reg_rd && reg_addr == 16'h0001 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
endmodule : zmpri_monitor
bind zmpri_top zmpri_monitor #(.JAM_CYCLES(JAM_CYCLES)) i_mon (
  .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .asm_in_idx(asm_in_idx),
  .asm_in_data(asm_in_data), .asm_out_idx(asm_out_idx), .asm_out_wr(asm_out_wr),
  .asm_out_data(asm_out_data), .sensor_pins(sensor_pins),
  .roller_motor_run(roller_motor_run), .upstream_neighbour_hold(upstream_neighbour_hold),
  .downstream_release(downstream_release)
);

// ---- zmpri_plc_model.sv ----
// controller model working the cyclic assemblies
// assumes the bench calls its tasks on a shared clock
`timescale 1ns/1ps
module zmpri_plc_model (
  input wire logic clk,
  output zmpri_pkg::zmpri_bidx_t in_idx,
  input zmpri_pkg::zmpri_byte_t in_data,
  output zmpri_pkg::zmpri_bidx_t out_idx,
  output logic out_wr,
  output zmpri_pkg::zmpri_byte_t out_data
);
  import zmpri_pkg::*;
  initial begin
    in_idx = 5'h1f;
    out_idx = 5'h00;
    out_wr = 1'b0;
    out_data = 8'h00;
  end
  ////////////////////////////////////////////////////////////////
  task automatic put(input logic [3:0] w, input zmpri_word_t v);
    @(posedge clk);
    out_idx <= {w, 1'b0};
    out_data <= v[15:8];
    out_wr <= 1'b1;
    @(posedge clk);
    out_idx <= {w, 1'b1};
    out_data <= v[7:0];
    @(posedge clk);
    out_wr <= 1'b0;
    out_data <= ~v[7:0];
  endtask : put
  task automatic get(input logic [3:0] w, output zmpri_word_t v);
    @(posedge clk);
    in_idx <= {w, 1'b0};
    @(posedge clk);
    in_idx <= {w, 1'b1};
    @(negedge clk);
    v[15:8] = in_data;
    @(negedge clk);
    v[7:0] = in_data;
  endtask : get
  // merge: hold neighbour, wake, await arrival, release
  task automatic merge(input int gap, output logic ok);
    zmpri_word_t s;
    int i;
    ok = 1'b0;
    get(4'h0, s);
    if (s[7:0] != 8'h01)
      return;
    put(4'h0, 16'h0100);
    repeat (gap) @(posedge clk);
    put(4'h0, 16'h1100);
    for (i = 0; i < 400 && !(s[7:0] inside {8'h04, 8'h05}); i++)
      get(4'h0, s);
    if (i == 400)
      return;
    repeat (gap) @(posedge clk);
    put(4'h0, 16'h0100);
    put(4'h0, 16'h0000);
    ok = 1'b1;
  endtask : merge
endmodule : zmpri_plc_model

// ---- tb.sv ----
// self-checking bench for the zone merge register bank
// assumes the model and monitor files compiled first
`timescale 1ns/1ps
`include "zmpri_params.svh"
module tb;
  import zmpri_pkg::*;
  localparam int unsigned JAM = 200;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  zmpri_word_t reg_wdata = 16'h0000;
  zmpri_word_t reg_rdata, lsp, rsp, aux, clf, udm, ddm;
  zmpri_word_t stat2 = 16'h5a3c;
  zmpri_bidx_t in_idx, out_idx;
  zmpri_byte_t in_data, out_data;
  logic out_wr, hold, rel;
  logic [3:0] sensor_pins = 4'h0;
  logic feed_pin = 1'b0;
  logic [1:0] motor;
  int n_errors = 0;
  int checked = 0;
  always #5 clk = ~clk;
  zmpri_top #(.JAM_CYCLES(JAM)) i_dut (
    .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .asm_in_idx(in_idx), .asm_in_data(in_data),
    .asm_out_idx(out_idx), .asm_out_wr(out_wr), .asm_out_data(out_data),
    .sensor_pins(sensor_pins), .upstream_feed_pin(feed_pin), .module_status2_in(stat2),
    .roller_motor_run(motor), .upstream_neighbour_hold(hold), .downstream_release(rel),
    .left_speed(lsp), .right_speed(rsp), .aux_out(aux), .clear_fault(clf),
    .up_dir_mode(udm), .dn_dir_mode(ddm)
  );
  zmpri_plc_model i_plc (.clk(clk), .in_idx(in_idx), .in_data(in_data),
    .out_idx(out_idx), .out_wr(out_wr), .out_data(out_data));
  ////////////////////////////////////////////////////////////////
  task automatic check(input string n, input zmpri_word_t seen, input zmpri_word_t exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input zmpri_word_t d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rc(input string n, input logic [15:0] a, input zmpri_word_t e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    check(n, reg_rdata, e);
  endtask : rc
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    wr(`ZMPRI_UP_ARR, 16'h1234);
    rc("up status", `ZMPRI_UP_STAT, 16'h0001);
    rc("dn status", `ZMPRI_DN_STAT, 16'h0001);
    rc("up arrivals", `ZMPRI_UP_ARR, 16'h0000);
    rc("unmapped", 16'h0001, 16'h0000);
    $display("test reset done");
  endtask : t_reset
  task automatic t_asm();
    zmpri_word_t v;
    i_plc.put(4'h2, 16'habcd);
    i_plc.put(4'h3, 16'h1234);
    i_plc.put(4'h8, 16'h0102);
    i_plc.put(4'h9, 16'h8001);
    i_plc.put(4'ha, 16'hffff);
    i_plc.put(4'hd, 16'h0203);
    i_plc.put(4'he, 16'h0405);
    repeat (2) @(posedge clk);
    check("left speed", lsp, 16'habcd);
    check("right speed", rsp, 16'h1234);
    check("clear fault", clf, 16'h0102);
    check("aux out", aux, 16'h8001);
    check("up dir", udm, 16'h0203);
    check("dn dir", ddm, 16'h0405);
    rc("left speed reg", `ZMPRI_LSPEED, 16'habcd);
    i_plc.get(4'h7, v);
    check("status word 2", v, 16'h5a3c);
    i_plc.get(4'hb, v);
    check("reserved in", v, 16'h0000);
    $display("test assemblies done");
  endtask : t_asm
  task automatic t_merge();
    logic ok;
    int i;
    fork
      i_plc.merge(5, ok);
      begin
        for (i = 0; i < 300 && !motor[0]; i++)
          @(posedge clk);
        check("neighbour held", {15'h0000, hold}, 16'h0001);
        repeat (8) @(posedge clk);
        sensor_pins <= 4'h1;
      end
    join
    check("merge ok", {15'h0000, ok}, 16'h0001);
    rc("up arrivals", `ZMPRI_UP_ARR, 16'h0001);
    rc("up departures", `ZMPRI_UP_DEP, 16'h0000);
    check("hold off", {15'h0000, hold}, 16'h0000);
    sensor_pins <= 4'h2;
    repeat (10) @(posedge clk);
    check("dn running", {15'h0000, rel}, 16'h0001);
    sensor_pins <= 4'h0;
    repeat (8) @(posedge clk);
    rc("up departures", `ZMPRI_UP_DEP, 16'h0001);
    rc("dn arrivals", `ZMPRI_DN_ARR, 16'h0001);
    $display("test merge done");
  endtask : t_merge
  task automatic t_release();
    wr(`ZMPRI_DISCH, 16'h0005);
    sensor_pins <= 4'h2;
    repeat (12) @(posedge clk);
    check("dn blocked", {14'h0000, motor}, 16'h0000);
    wr(`ZMPRI_DN_REL, 16'h0001);
    wr(`ZMPRI_DISCH, 16'h0001);
    repeat (6) @(posedge clk);
    check("dn released", {15'h0000, rel}, 16'h0001);
    sensor_pins <= 4'h0;
    repeat (8) @(posedge clk);
    rc("dn release count", `ZMPRI_DN_REL, 16'h0001);
    sensor_pins <= 4'h2;
    repeat (10) @(posedge clk);
    check("dn accumulates", {15'h0000, motor[1]}, 16'h0000);
    wr(`ZMPRI_DN_CTRL, 16'h0000);
    repeat (6) @(posedge clk);
    check("dn resumes", {15'h0000, motor[1]}, 16'h0001);
    sensor_pins <= 4'h0;
    repeat (8) @(posedge clk);
    $display("test release done");
  endtask : t_release
  task automatic t_jam();
    sensor_pins <= 4'h1;
    repeat (JAM + 20) @(posedge clk);
    check("jam stop", {15'h0000, motor[0]}, 16'h0000);
    rc("jam flag", `ZMPRI_MSTAT1, 16'h0001);
    rc("sensor inputs", `ZMPRI_SENSOR_IN, 16'h0001);
    wr(`ZMPRI_UP_JAMCLR, 16'h0001);
    repeat (4) @(posedge clk);
    check("jam run", {15'h0000, motor[0]}, 16'h0001);
    sensor_pins <= 4'h0;
    rc("jam cleared", `ZMPRI_MSTAT1, 16'h0000);
    $display("test jam done");
  endtask : t_jam
  task automatic t_wake();
    repeat (8) @(posedge clk);
    feed_pin <= 1'b1;
    repeat (8) @(posedge clk);
    check("feed wake", {15'h0000, motor[0]}, 16'h0001);
    feed_pin <= 1'b0;
    wr(`ZMPRI_INDUCT, `ZMPRI_INDUCT_WAKE);
    repeat (8) @(posedge clk);
    check("induct wake", {15'h0000, motor[0]}, 16'h0001);
    wr(`ZMPRI_INDUCT, 16'h0001);
    wr(`ZMPRI_UP_CTRL, 16'h0001);
    sensor_pins <= 4'h1;
    repeat (10) @(posedge clk);
    check("up accumulates", {15'h0000, motor[0]}, 16'h0000);
    rc("up held status", `ZMPRI_UP_STAT, 16'h0005);
    wr(`ZMPRI_UP_CTRL, 16'h0000);
    sensor_pins <= 4'h0;
    repeat (8) @(posedge clk);
    $display("test wake done");
  endtask : t_wake
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_asm();
    t_merge();
    t_release();
    t_jam();
    t_wake();
    report_and_stop();
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
endmodule : tb
